//--- design/port5_bit0_function_select.sv
// Function select for one port pin with AXI4-Lite setting registers.
//
// Function
// - Current-controlled output when enable is one, level is 1 to 3, output and latch zero, and touch and event are off.
// - Plain digital input when direction is input and touch, event and drive are off.
// - Push-pull output of the latch when not open-drain, output and all modes off.
// - Open-drain output of the latch when open-drain, output and all modes off.
// - Touch channel when touch is one, input, and event and drive are off.
// - Event output when event is one, output, and touch and drive are off.
// - Event, interrupt and serial inputs are fed when the pin is a plain input.
// - Serial bidirectional use needs open-drain, output, latch one and all modes off.
// - Drive enable zero means digital function and one means current control.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

`include "pin_cfg.svh"

module port5_bit0_function_select #(
  parameter int SETTLE_COUNT = `SETTLE_CYCLES     // Cycles for the drive to settle.
) (
  input  wire logic        aclk,                 // System clock, 25 MHz.
  input  wire logic        aresetn,              // Synchronous reset, active low.
  input  wire logic [11:0] s_axi_awaddr,         // Write address.
  input  wire logic        s_axi_awvalid,        // Write address valid.
  output logic             s_axi_awready,        // Write address ready.
  input  wire logic [31:0] s_axi_wdata,          // Write data.
  input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes.
  input  wire logic        s_axi_wvalid,         // Write data valid.
  output logic             s_axi_wready,         // Write data ready.
  output logic [1:0]       s_axi_bresp,          // Write response.
  output logic             s_axi_bvalid,         // Write response valid.
  input  wire logic        s_axi_bready,         // Write response ready.
  input  wire logic [11:0] s_axi_araddr,         // Read address.
  input  wire logic        s_axi_arvalid,        // Read address valid.
  output logic             s_axi_arready,        // Read address ready.
  output logic [31:0]      s_axi_rdata,          // Read data.
  output logic [1:0]       s_axi_rresp,          // Read response.
  output logic             s_axi_rvalid,         // Read data valid.
  input  wire logic        s_axi_rready,         // Read data ready.
  input  wire logic        pin_in,               // Pin level seen by the input buffer.
  output logic             pin_out,              // Pin output level.
  output logic             pin_oe,               // Pin output enable, high while driving.
  input  wire logic        serial_data_out,      // Serial unit data output.
  input  wire logic        event_link_output,    // Event link output source.
  output logic             event_link_input,     // Event link input from the pin.
  output logic             external_interrupt_in, // Interrupt input from the pin.
  output logic             serial_data_in,       // Serial data input from the pin.
  output logic             touch_channel_zero,   // Touch channel connection active.
  output logic             current_controlled_out, // Current-controlled drive active.
  output logic [2:0]       current_drive_level_field // Drive level to the analog cell.
);

  // The settle counter is 16 bits wide and has to count at least one cycle.
  if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65535) begin : g_bad_settle
    $error("SETTLE_COUNT out of range");
  end

  // ------------------------------------------------------------
  // Setting registers
  // ------------------------------------------------------------
  logic [`CONTROL_WIDTH-1:0] control;
  logic [`LEVEL_WIDTH-1:0]   level;
  logic [15:0]               settle_cnt;
  logic                      aw_held;
  logic                      w_held;
  logic [11:0]               aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  pin_pkg::read_state_t      rd_state;

  wire latch           = control[`BIT_LATCH];
  wire pin_direction_bit       = control[`BIT_DIRECTION];
  wire open_drain_select_bit   = control[`BIT_OPEN_DRAIN];
  wire touch_mode_select_bit   = control[`BIT_TOUCH];
  wire event_output_select_bit = control[`BIT_EVENT];
  wire current_drive_enable_bit3 = control[`BIT_DRIVE_EN];

  pin_pkg::pin_func_t func;

  pin_func_decode u_decode (
    .latch      (latch),
    .direction  (pin_direction_bit),
    .open_drain (open_drain_select_bit),
    .touch      (touch_mode_select_bit),
    .event_out  (event_output_select_bit),
    .drive_en   (current_drive_enable_bit3),
    .level      (level),
    .func       (func)
  );

  // ------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire have_aw   = aw_held || aw_take;
  wire have_w    = w_held || w_take;
  wire do_write  = have_aw && have_w && !s_axi_bvalid;
  wire [11:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_ctrl   = do_write && wr_addr == `OFS_CONTROL && wr_strb[0];
  wire wr_level  = do_write && wr_addr == `OFS_LEVEL && wr_strb[0];
  wire wr_known  = wr_addr == `OFS_CONTROL || wr_addr == `OFS_LEVEL ||
                   wr_addr == `OFS_STATUS;
  wire [`CONTROL_WIDTH-1:0] next_control = wr_data[`CONTROL_WIDTH-1:0];
  wire drive_rise = wr_ctrl && next_control[`BIT_DRIVE_EN] && !current_drive_enable_bit3;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= have_aw && !do_write;
      w_held  <= have_w && !do_write;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= `CONTROL_RESET;
      level   <= `LEVEL_RESET;
    end else begin
      if (wr_ctrl) begin
        control <= next_control;
      end
      if (wr_level) begin
        level <= wr_data[`LEVEL_WIDTH-1:0];
      end
    end
  end

  // Settle counter runs after drive enable goes to one so software can poll it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt <= 16'h0000;
    end else if (drive_rise) begin
      settle_cnt <= 16'(SETTLE_COUNT);
    end else if (settle_cnt != 16'h0000) begin
      settle_cnt <= settle_cnt - 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  wire settling = settle_cnt != 16'h0000;
  wire [31:0] status_word = {23'h000000, settling, func == pin_pkg::FUNC_UNSUPPORTED,
                             3'h0, func};
  wire rd_ctrl  = s_axi_araddr == `OFS_CONTROL;
  wire rd_level = s_axi_araddr == `OFS_LEVEL;
  wire rd_stat  = s_axi_araddr == `OFS_STATUS;
  wire [31:0] rd_word = rd_ctrl  ? {26'h0000000, control} :
                        rd_level ? {29'h00000000, level} :
                        rd_stat  ? status_word : 32'h0000_0000;
  wire rd_known = rd_ctrl || rd_level || rd_stat;

  assign s_axi_arready = rd_state == pin_pkg::RD_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state     <= pin_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else begin
      unique case (rd_state)
        pin_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state     <= pin_pkg::RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
          end
        end
        pin_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state     <= pin_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin routing
  // ------------------------------------------------------------
  wire f_input = func == pin_pkg::FUNC_INPUT;
  wire f_pp    = func == pin_pkg::FUNC_PUSH_PULL;
  wire f_od    = func == pin_pkg::FUNC_OPEN_DRAIN;
  wire f_bidir = func == pin_pkg::FUNC_SERIAL_BIDIR;
  wire f_event = func == pin_pkg::FUNC_EVENT_OUT;
  wire f_cur   = func == pin_pkg::FUNC_CURRENT;

  // Serial output is ANDed with the latch, so the serial unit holds one for plain port use.
  wire       od_level       = latch && serial_data_out;
  wire       next_pin_out   = f_event ? event_link_output : f_pp ? od_level : 1'b0;
  wire       next_pin_oe    = f_event || f_pp || ((f_od || f_bidir) && !od_level);
  wire       next_feed      = f_input && pin_in;
  wire       next_serial_in = (f_input || f_bidir) && pin_in;
  wire       next_touch     = func == pin_pkg::FUNC_TOUCH;
  wire [2:0] next_level_out = f_cur ? level : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out                   <= 1'b0;
      pin_oe                    <= 1'b0;
      event_link_input          <= 1'b0;
      external_interrupt_in     <= 1'b0;
      serial_data_in            <= 1'b0;
      touch_channel_zero        <= 1'b0;
      current_controlled_out    <= 1'b0;
      current_drive_level_field <= 3'h0;
    end else begin
      pin_out                   <= next_pin_out;
      pin_oe                    <= next_pin_oe;
      event_link_input          <= next_feed;
      external_interrupt_in     <= next_feed;
      serial_data_in            <= next_serial_in;
      touch_channel_zero        <= next_touch;
      current_controlled_out    <= f_cur;
      current_drive_level_field <= next_level_out;
    end
  end

endmodule

`default_nettype wire

//--- design/pin_cfg.svh
// Offsets, field positions, reset values and timing counts for the pin function select block.
`ifndef PIN_CFG_SVH
`define PIN_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CONTROL       12'h000
`define OFS_LEVEL         12'h004
`define OFS_STATUS        12'h008

// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define BIT_LATCH         0
`define BIT_DIRECTION     1
`define BIT_OPEN_DRAIN    2
`define BIT_TOUCH         3
`define BIT_EVENT         4
`define BIT_DRIVE_EN      5
`define CONTROL_WIDTH     6
`define LEVEL_WIDTH       3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CONTROL_RESET     6'h02
`define LEVEL_RESET       3'h0

// ------------------------------------------------------------
// Drive level range and settle time
// ------------------------------------------------------------
`define LEVEL_MIN         3'h1
`define LEVEL_MAX         3'h3
`define SETTLE_NS         10000
`define CLOCK_NS          40
`define SETTLE_CYCLES     (`SETTLE_NS / `CLOCK_NS)

`endif

//--- design/pin_pkg.sv
// Types shared by the pin function select block.
package pin_pkg;

  typedef enum logic [3:0] {
    FUNC_INPUT,
    FUNC_PUSH_PULL,
    FUNC_OPEN_DRAIN,
    FUNC_TOUCH,
    FUNC_EVENT_OUT,
    FUNC_CURRENT,
    FUNC_SERIAL_BIDIR,
    FUNC_UNSUPPORTED
  } pin_func_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_DATA
  } read_state_t;

endpackage

//--- design/pin_func_decode.sv
// Decoder that maps the setting bits onto the active pin function.
`timescale 1ns/100ps
`default_nettype none

`include "pin_cfg.svh"

module pin_func_decode (
  input  wire logic              latch,       // Output latch value.
  input  wire logic              direction,   // One selects input.
  input  wire logic              open_drain,  // Open-drain output select.
  input  wire logic              touch,       // Touch mode select.
  input  wire logic              event_out,   // Event output mode select.
  input  wire logic              drive_en,    // Current drive enable.
  input  wire logic [2:0]        level,       // Current drive level field.
  output var pin_pkg::pin_func_t func         // Decoded function.
);

  wire modes_off  = !touch && !event_out && !drive_en;
  wire level_ok   = (level >= `LEVEL_MIN) && (level <= `LEVEL_MAX);
  wire is_current = drive_en && level_ok && !direction && !latch && !touch && !event_out;
  wire is_touch   = touch && direction && !event_out && !drive_en;
  wire is_event   = event_out && !direction && !touch && !drive_en;
  wire is_input   = direction && modes_off;
  wire is_bidir   = open_drain && !direction && latch && modes_off;
  wire is_od      = open_drain && !direction && modes_off;
  wire is_pp      = !open_drain && !direction && modes_off;

  assign func = is_current ? pin_pkg::FUNC_CURRENT :
                is_touch   ? pin_pkg::FUNC_TOUCH :
                is_event   ? pin_pkg::FUNC_EVENT_OUT :
                is_input   ? pin_pkg::FUNC_INPUT :
                is_bidir   ? pin_pkg::FUNC_SERIAL_BIDIR :
                is_od      ? pin_pkg::FUNC_OPEN_DRAIN :
                is_pp      ? pin_pkg::FUNC_PUSH_PULL :
                             pin_pkg::FUNC_UNSUPPORTED;

endmodule

`default_nettype wire

//--- tb/port5_chk.sv
// Checker for the pin function select block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none

module port5_chk #(
  parameter int SETTLE_COUNT = 250           // Settle count of the design.
) (
  input  wire logic       aclk,                      // Clock.
  input  wire logic       aresetn,                   // Reset, active low.
  input  wire logic       s_axi_awready,             // Write address ready.
  input  wire logic       s_axi_bvalid,              // Write response valid.
  input  wire logic       s_axi_bready,              // Write response ready.
  input  wire logic       s_axi_arready,             // Read address ready.
  input  wire logic [31:0] s_axi_rdata,              // Read data.
  input  wire logic       s_axi_rvalid,              // Read data valid.
  input  wire logic       s_axi_rready,              // Read data ready.
  input  wire logic       pin_in,                    // Pin level.
  input  wire logic       pin_oe,                    // Pin enable.
  input  wire logic       event_link_input,          // Event input.
  input  wire logic       external_interrupt_in,     // Interrupt input.
  input  wire logic       serial_data_in,            // Serial input.
  input  wire logic       touch_channel_zero,        // Touch active.
  input  wire logic       current_controlled_out,    // Current drive active.
  input  wire logic [2:0] current_drive_level_field  // Drive level.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");
  property p_aw_blocked; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw_blocked: assert property (p_aw_blocked) else $error("write taken while answering");
  property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blocked: assert property (p_ar_blocked) else $error("read taken while answering");
  property p_rvalid_ends; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rvalid_ends: assert property (p_rvalid_ends) else $error("read answer repeated");
  property p_current_drive;
    current_controlled_out |-> !pin_oe && current_drive_level_field inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_current_drive: assert property (p_current_drive) else $error("bad current drive");
  property p_level_idle; !current_controlled_out |-> current_drive_level_field == 3'h0; endproperty
  a_level_idle: assert property (p_level_idle) else $error("level out of current mode");
  property p_touch_alone;
    touch_channel_zero |-> !pin_oe && !current_controlled_out && !event_link_input;
  endproperty
  a_touch_alone: assert property (p_touch_alone) else $error("touch mixed with others");
  property p_inputs_fed;
    event_link_input |-> external_interrupt_in && serial_data_in && !pin_oe && $past(pin_in);
  endproperty
  a_inputs_fed: assert property (p_inputs_fed) else $error("input feeds disagree");
  property p_reset_quiet;
    $rose(aresetn) |-> !pin_oe && !s_axi_bvalid && !s_axi_rvalid && !current_controlled_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_current: cover property (current_controlled_out);
  c_touch: cover property (touch_channel_zero);
endmodule

bind port5_bit0_function_select port5_chk #(.SETTLE_COUNT(SETTLE_COUNT)) port5_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_oe(pin_oe),
  .event_link_input(event_link_input), .external_interrupt_in(external_interrupt_in),
  .serial_data_in(serial_data_in), .touch_channel_zero(touch_channel_zero),
  .current_controlled_out(current_controlled_out),
  .current_drive_level_field(current_drive_level_field));
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench for the pin function select block.
`timescale 1ns/100ps
`default_nettype none
`include "pin_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end

module tb_top;
  typedef struct packed {logic [5:0] c; logic [2:0] l; logic [3:0] f; logic oe; logic o;} row_t;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pin_in = 1'b0, sdo = 1'b1, elo = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, eli, eint, sdi, tch, cur;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] lvl;
  int failures = 0, total_checks = 0;
  row_t rows [16] = '{
    '{6'h02,3'h0,4'h0,1'h0,1'h0}, '{6'h07,3'h0,4'h0,1'h0,1'h0}, '{6'h00,3'h0,4'h1,1'h1,1'h0},
    '{6'h01,3'h0,4'h1,1'h1,1'h1}, '{6'h04,3'h0,4'h2,1'h1,1'h0}, '{6'h05,3'h0,4'h6,1'h0,1'h0},
    '{6'h0A,3'h0,4'h3,1'h0,1'h0}, '{6'h10,3'h0,4'h4,1'h1,1'h1}, '{6'h15,3'h0,4'h4,1'h1,1'h1},
    '{6'h18,3'h0,4'h7,1'h0,1'h0}, '{6'h22,3'h1,4'h7,1'h0,1'h0}, '{6'h20,3'h1,4'h5,1'h0,1'h0},
    '{6'h20,3'h3,4'h5,1'h0,1'h0}, '{6'h20,3'h4,4'h7,1'h0,1'h0}, '{6'h21,3'h2,4'h7,1'h0,1'h0},
    '{6'h30,3'h2,4'h7,1'h0,1'h0}};

  port5_bit0_function_select #(.SETTLE_COUNT(8)) port5_bit0_function_select_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .serial_data_out(sdo),
    .event_link_output(elo), .event_link_input(eli), .external_interrupt_in(eint),
    .serial_data_in(sdi), .touch_channel_zero(tch), .current_controlled_out(cur),
    .current_drive_level_field(lvl));

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 64) begin failures++; wrap_up(); end
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed,
                    input logic [31:0] mk);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 64) begin failures++; wrap_up(); end
    `CHK("rresp", er, rresp)
    `CHK("rdata", ed, rdata & mk)
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [3:0] f;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_CONTROL, 2'h0, 32'h00000002, 32'hFFFFFFFF);
    rd(`OFS_LEVEL, 2'h0, 32'h00000000, 32'hFFFFFFFF);
    rd(`OFS_STATUS, 2'h0, 32'h00000000, 32'h000001FF);
    for (int i = 0; i < 16; i++) begin
      f = rows[i].f;
      pin_in <= i[0];
      wr(`OFS_LEVEL, {29'h0, rows[i].l}, 4'hF, 2'h0);
      wr(`OFS_CONTROL, {26'h0, rows[i].c}, 4'hF, 2'h0);
      repeat (2) @(posedge aclk);
      #1;
      `CHK("pin_oe", rows[i].oe, pin_oe)
      if (rows[i].oe) `CHK("pin_out", rows[i].o, pin_out)
      `CHK("touch", f == 4'h3, tch)
      `CHK("current", f == 4'h5, cur)
      `CHK("level", (f == 4'h5) ? rows[i].l : 3'h0, lvl)
      `CHK("event_in", (f == 4'h0) & i[0], eli)
      `CHK("irq_in", (f == 4'h0) & i[0], eint)
      `CHK("serial_in", (f == 4'h0 || f == 4'h6) & i[0], sdi)
      rd(`OFS_STATUS, 2'h0, {24'h0, f == 4'h7, 3'h0, f}, 32'h000000FF);
    end
    wr(`OFS_CONTROL, 32'h00000002, 4'hF, 2'h0);
    wr(`OFS_CONTROL, 32'h00000022, 4'hF, 2'h0);
    wr(`OFS_CONTROL, 32'h00000020, 4'hF, 2'h0);
    rd(`OFS_STATUS, 2'h0, 32'h00000105, 32'h000001FF);
    repeat (20) @(posedge aclk);
    rd(`OFS_STATUS, 2'h0, 32'h00000005, 32'h000001FF);
    wr(`OFS_CONTROL, 32'h00000001, 4'h0, 2'h0);
    rd(`OFS_CONTROL, 2'h0, 32'h00000020, 32'hFFFFFFFF);
    wr(`OFS_CONTROL, 32'h00000001, 4'hF, 2'h0);
    sdo <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    `CHK("pin_out_sdo", 1'b0, pin_out)
    wr(`OFS_CONTROL, 32'h00000005, 4'hF, 2'h0);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("oe_bidir_low", 1'b1, pin_oe)
    `CHK("out_bidir_low", 1'b0, pin_out)
    wr(`OFS_CONTROL, 32'h00000010, 4'hF, 2'h0);
    sdo <= 1'b1;
    elo <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    `CHK("oe_event", 1'b1, pin_oe)
    `CHK("out_event_low", 1'b0, pin_out)
    wr(12'h00C, 32'h00000001, 4'hF, 2'h2);
    rd(12'h00C, 2'h2, 32'h00000000, 32'hFFFFFFFF);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK("oe_reset", 1'b0, pin_oe)
    rd(`OFS_CONTROL, 2'h0, 32'h00000002, 32'hFFFFFFFF);
    wrap_up();
  end
endmodule
`default_nettype wire
